/* inc/fluh_defines.vh */
`ifndef FLUH_DEFINES_VH
`define FLUH_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FLUH_IDX_STATUS 8'h48
`define FLUH_IDX_CTRL 8'h4a
`define FLUH_IDX_PWMVAL 8'h4c
`define FLUH_IDX_OFFSET 8'h4e
`define FLUH_IDX_HYST 8'h4f
`define FLUH_IDX_E1TEMP 8'h50
`define FLUH_IDX_E1DUTY 8'h51

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FLUH_CTRL_HIRES_TEMP 0
`define FLUH_CTRL_HIRES_DUTY 1
`define FLUH_CTRL_FREQ_FAST 2
`define FLUH_CTRL_PROG_EN 5
`define FLUH_HYST_MSB 4
`define FLUH_OFFSET_MSB 5
`define FLUH_TEMP_HALF_BIT 7
`define FLUH_DUTY_EXT_LSB 6
`define FLUH_DUTY_LOW_MSB 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FLUH_RST_CTRL 8'h00
`define FLUH_RST_OFFSET 6'h00
`define FLUH_RST_HYST 5'h04
`define FLUH_RST_E1TEMP 8'h7f
`define FLUH_RST_E1DUTY 8'h3f

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FLUH_CLK_HZ 40000000
`define FLUH_FAST_PWM_HZ 22500
`define FLUH_SLOW_PWM_HZ 30
`define FLUH_STEPS_WIDE 256
`define FLUH_STEPS_NARROW 64

`endif

/* rtl/fluh_pwm.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Duty-cycle generator for the open-drain fan output
// ----------------------------------------------------------------
module fluh_pwm #(
    parameter [14:0] FAST_DIV = 15'h0006,
    parameter [14:0] SLOW_DIV = 15'h5161
)
(
    input wire hclk,
    input wire hresetn,
    input wire fast_sel,
    input wire wide,
    input wire [7:0] duty,
    output wire pwm_o,
    output wire pwm_oe
);

    reg [14:0] div_q;
    reg [7:0] step_q;
    reg oe_q;
    wire [14:0] div_load;
    wire tick;
    wire [7:0] step_top;

    assign div_load = fast_sel ? FAST_DIV - 15'h0001 : SLOW_DIV - 15'h0001;
    assign tick = (div_q == 15'h0000);
    // Six-bit duty runs a 64-step period, so full scale 63 is on for 63 of 64 steps
    assign step_top = wide ? 8'hff : 8'h3f;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q <= 15'h0000;
            step_q <= 8'h00;
            oe_q <= 1'b1;
        end
        else
        begin
            if (tick)
                div_q <= div_load;
            else
                div_q <= div_q - 15'h0001;
            if (tick)
            begin
                if (step_q >= step_top)
                    step_q <= 8'h00;
                else
                    step_q <= step_q + 8'h01;
            end
            // Released (fan on) while the step is below the duty value
            oe_q <= !(step_q < duty);
        end
    end

    assign pwm_o = 1'b0;
    assign pwm_oe = oe_q;

endmodule // fluh_pwm

`default_nettype wire

/* rtl/fluh_top.v */
// What this block does
// - Hysteresis of 0..31 degrees, one degree per step, held in five bits.
// - Upper three bits of the hysteresis register always read zero.
// - High-res temperature mode adds the top entry bit; low-res keeps it zero.
// - Entry covers 0..127.5 C in half degrees, or 0..127 C whole.
// - Compare nine reading bits in high-res mode, eight in low-res mode.
// - Table limits are unsigned; their sign is always taken as zero.
// - Table offset is added to entry limits to reach above 127 C.
// - High-res duty joins two extended bits with six low bits.
// - Extended duty bits act only when the 22.5 kHz rate is chosen.
// - Low-res duty uses the six low bits of the first duty entry.
// - Table offset is unsigned, one degree steps, at most 63 degrees.
`include "fluh_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module fluh_top #(
    parameter [14:0] SLOW_DIV = 15'h5161
)
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire [31:0] hrdata,
    output wire hresp,
    input wire [10:0] remote_temp,
    output wire lut_active,
    output wire [7:0] pwm_value,
    output wire pwm_o,
    output wire pwm_oe
);

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    // Integer division rounds the fast step down, so the rate runs a bit fast
    localparam [31:0] FAST_DIV_FULL = `FLUH_CLK_HZ /
        (`FLUH_FAST_PWM_HZ * `FLUH_STEPS_WIDE);
    localparam [14:0] FAST_DIV = FAST_DIV_FULL[14:0];

    // ----------------------------------------------------------------
    // Bus slave: address phase capture
    // ----------------------------------------------------------------
    reg wr_q;
    reg [7:0] idx_q;
    reg [31:0] hrdata_q;
    wire take;
    wire good;
    wire [7:0] idx_a;

    // Only aligned word accesses inside the 1 KB window decode
    assign take = hsel & hready & htrans[1];
    assign good = (haddr[31:10] == 22'h000000) &
        (haddr[1:0] == 2'b00) & (hsize == 3'b010);
    assign idx_a = haddr[9:2];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            idx_q <= 8'h00;
        end
        else if (hready)
        begin
            wr_q <= take & good & hwrite;
            idx_q <= idx_a;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg [5:0] offset_q;
    reg [5:0] offset_d;
    reg [4:0] hyst_q;
    reg [4:0] hyst_d;
    reg [7:0] e1temp_q;
    reg [7:0] e1temp_d;
    reg [7:0] e1duty_q;
    reg [7:0] e1duty_d;
    wire prog_en;
    wire hires_t;
    wire hires_t_d;
    wire hires_d;
    wire fast_sel;
    wire ext_ok;

    assign prog_en = ctrl_q[`FLUH_CTRL_PROG_EN];
    assign hires_t = ctrl_q[`FLUH_CTRL_HIRES_TEMP];
    assign hires_t_d = ctrl_d[`FLUH_CTRL_HIRES_TEMP];
    assign hires_d = ctrl_q[`FLUH_CTRL_HIRES_DUTY];
    assign fast_sel = ctrl_q[`FLUH_CTRL_FREQ_FAST];
    assign ext_ok = hires_d & fast_sel;

    always @*
    begin
        ctrl_d = ctrl_q;
        offset_d = offset_q;
        hyst_d = hyst_q;
        e1temp_d = e1temp_q;
        e1duty_d = e1duty_q;
        if (wr_q)
        begin
            case (idx_q)
                `FLUH_IDX_CTRL:
                begin
                    ctrl_d = {2'b00, hwdata[5], 2'b00, hwdata[2:0]};
                end
                `FLUH_IDX_OFFSET:
                begin
                    // Six bits cap the offset at 63 degrees
                    offset_d = hwdata[`FLUH_OFFSET_MSB:0];
                end
                `FLUH_IDX_HYST:
                begin
                    hyst_d = hwdata[`FLUH_HYST_MSB:0];
                end
                `FLUH_IDX_E1TEMP:
                begin
                    // Entries are frozen unless programming is enabled
                    if (prog_en)
                        e1temp_d = hwdata[7:0];
                end
                `FLUH_IDX_E1DUTY:
                begin
                    if (prog_en)
                        e1duty_d = hwdata[7:0];
                end
                default:
                begin
                    ctrl_d = ctrl_q;
                end
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= `FLUH_RST_CTRL;
            offset_q <= `FLUH_RST_OFFSET;
            hyst_q <= `FLUH_RST_HYST;
            e1temp_q <= `FLUH_RST_E1TEMP;
            e1duty_q <= `FLUH_RST_E1DUTY;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            offset_q <= offset_d;
            hyst_q <= hyst_d;
            e1temp_q <= e1temp_d;
            e1duty_q <= e1duty_d;
        end
    end

    // ----------------------------------------------------------------
    // Effective entry fields
    // ----------------------------------------------------------------
    wire [6:0] entry1_limit_whole_degrees;
    wire entry1_limit_half_degree_bit;
    wire [1:0] entry1_duty_extended_bits;
    wire [5:0] entry1_duty_low_bits;
    wire [7:0] e1temp_view;
    wire [7:0] e1duty_view;

    assign entry1_limit_whole_degrees = e1temp_q[6:0];
    // The half-degree bit is dead in low-res mode
    assign entry1_limit_half_degree_bit =
        e1temp_q[`FLUH_TEMP_HALF_BIT] & hires_t;
    assign entry1_duty_extended_bits = ext_ok ?
        e1duty_q[7:`FLUH_DUTY_EXT_LSB] : 2'b00;
    assign entry1_duty_low_bits = e1duty_q[`FLUH_DUTY_LOW_MSB:0];

    // Read views use next values so a write is seen by the next read
    assign e1temp_view = {e1temp_d[7] & hires_t_d, e1temp_d[6:0]};
    assign e1duty_view = (ctrl_d[`FLUH_CTRL_HIRES_DUTY] &
        ctrl_d[`FLUH_CTRL_FREQ_FAST]) ? e1duty_d :
        {2'b00, e1duty_d[5:0]};

    // ----------------------------------------------------------------
    // Limit and reading in half degrees
    // ----------------------------------------------------------------
    reg [9:0] limit_half;
    reg [9:0] temp_half;
    reg [9:0] lower_half;
    wire [9:0] hyst_half;
    wire [9:0] offs_half;

    // Entry is unsigned 0..127.5, offset doubles into half degrees
    assign offs_half = {3'b000, offset_q, 1'b0};
    assign hyst_half = {4'b0000, hyst_q, 1'b0};

    always @*
    begin
        // Sign bit is taken as zero, so the limit is never negative
        limit_half = {2'b00, entry1_limit_whole_degrees,
            entry1_limit_half_degree_bit} + offs_half;
        // Reading is unsigned eighths; keep nine or eight bits
        if (hires_t)
            temp_half = {1'b0, remote_temp[10:2]};
        else
            temp_half = {1'b0, remote_temp[10:3], 1'b0};
        // Hysteresis clamps at zero so a small limit cannot wrap
        if (limit_half > hyst_half)
            lower_half = limit_half - hyst_half;
        else
            lower_half = 10'h000;
    end

    // ----------------------------------------------------------------
    // Table decision with hysteresis
    // ----------------------------------------------------------------
    reg active_q;
    reg [7:0] pwm_q;
    reg active_d;
    reg [7:0] duty_sel;

    // Rise above the limit turns on; fall to limit minus hysteresis off
    always @*
    begin
        if (active_q)
            active_d = (temp_half > lower_half);
        else
            active_d = (temp_half > limit_half);
        // Inactive table drives no duty, so the fan line stays pulled low
        if (active_d)
            duty_sel = {entry1_duty_extended_bits,
                entry1_duty_low_bits};
        else
            duty_sel = 8'h00;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            active_q <= 1'b0;
            pwm_q <= 8'h00;
        end
        else
        begin
            active_q <= active_d;
            pwm_q <= duty_sel;
        end
    end

    assign lut_active = active_q;
    assign pwm_value = pwm_q;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    reg [7:0] rd_byte;

    always @*
    begin
        case (idx_a)
            `FLUH_IDX_STATUS:
            begin
                rd_byte = {7'h00, active_q};
            end
            `FLUH_IDX_CTRL:
            begin
                rd_byte = ctrl_d;
            end
            `FLUH_IDX_PWMVAL:
            begin
                rd_byte = pwm_q;
            end
            `FLUH_IDX_OFFSET:
            begin
                rd_byte = {2'b00, offset_d};
            end
            `FLUH_IDX_HYST:
            begin
                rd_byte = {3'b000, hyst_d};
            end
            `FLUH_IDX_E1TEMP:
            begin
                rd_byte = e1temp_view;
            end
            `FLUH_IDX_E1DUTY:
            begin
                rd_byte = e1duty_view;
            end
            default:
            begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // Loaded at the address phase so the word stands through the data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h00000000;
        else if (take & !hwrite)
            hrdata_q <= good ? {24'h000000, rd_byte} : 32'h00000000;
    end

    // Zero wait states: every access completes in one data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // ----------------------------------------------------------------
    // Output stage
    // ----------------------------------------------------------------
    fluh_pwm #(
        .FAST_DIV(FAST_DIV),
        .SLOW_DIV(SLOW_DIV)
    )
    u_pwm (
        .hclk(hclk),
        .hresetn(hresetn),
        .fast_sel(fast_sel),
        .wide(ext_ok),
        .duty(pwm_q),
        .pwm_o(pwm_o),
        .pwm_oe(pwm_oe)
    );

endmodule // fluh_top

`default_nettype wire

/* tb/fluh_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fluh_defines.vh"
// ----
// Port checker
// ----
module fluh_top_monitor #(
    parameter [14:0] SLOW_DIV = 15'h5161
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [10:0] remote_temp,
    input wire logic lut_active,
    input wire logic [7:0] pwm_value,
    input wire logic pwm_o,
    input wire logic pwm_oe
);
    logic [7:0] ctl_q;
    logic wc_q;
    logic [1:0] up_q;
    logic ap;
    logic wr;
    logic [7:0] ctl_n;
    assign ap = hsel && hready && htrans[1] && hsize == 3'b010;
    assign wr = ap && hwrite;
    // Mode as the design holds it once a pending write lands
    assign ctl_n = wc_q ? hwdata[7:0] : ctl_q;
    // Mode shadow follows the write data phase, as the register does
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl_q <= 8'h00;
            wc_q <= 1'b0;
            up_q <= 2'h0;
        end
        else
        begin
            wc_q <= wr && haddr == `FLUH_IDX_CTRL * 4;
            if (wc_q)
                ctl_q <= hwdata[7:0];
            if (up_q != 2'h3)
                up_q <= up_q + 2'h1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd(logic [31:0] a);
        ap && !hwrite && haddr == a;
    endsequence
    sequence s_calm;
        up_q == 2'h3 && !wr && $stable(remote_temp[10:2]);
    endsequence
    sequence s_hot;
        up_q == 2'h3 && remote_temp[10:8] == 3'h7;
    endsequence
    sequence s_cold;
        up_q == 2'h3 && remote_temp == 11'h000;
    endsequence
    property p_frac;
        s_calm [*3] |=> $stable(lut_active) && $stable(pwm_value);
    endproperty
    a_frac: assert property (p_frac)
        else $error("output moved on unused reading bits");
    property p_hot;
        s_hot [*3] |-> lut_active;
    endproperty
    a_hot: assert property (p_hot)
        else $error("limit not unsigned");
    property p_cold;
        s_cold [*3] |-> !lut_active;
    endproperty
    a_cold: assert property (p_cold)
        else $error("active at zero reading");
    property p_idle;
        !lut_active |-> pwm_value == 8'h00;
    endproperty
    a_idle: assert property (p_idle)
        else $error("duty while inactive");
    property p_oe;
        (pwm_value == 8'h00) [*3] |-> pwm_oe;
    endproperty
    a_oe: assert property (p_oe)
        else $error("fan line released at zero duty");
    property p_ext;
        (up_q == 2'h3 && !(ctl_q[1] && ctl_q[2])) [*3]
            |-> pwm_value[7:6] == 2'b00;
    endproperty
    a_ext: assert property (p_ext)
        else $error("extended duty bits outside fast wide mode");
    property p_hyst;
        s_rd(`FLUH_IDX_HYST * 4) |=> hrdata[31:5] == 27'h0;
    endproperty
    a_hyst: assert property (p_hyst)
        else $error("hysteresis upper bits not zero");
    property p_off;
        s_rd(`FLUH_IDX_OFFSET * 4) |=> hrdata[31:6] == 26'h0;
    endproperty
    a_off: assert property (p_off)
        else $error("offset above six bits");
    property p_temp;
        s_rd(`FLUH_IDX_E1TEMP * 4) ##0 !ctl_n[0] |=> hrdata[31:7] == 25'h0;
    endproperty
    a_temp: assert property (p_temp)
        else $error("limit top bit in low resolution");
    property p_stat;
        s_rd(`FLUH_IDX_STATUS * 4) |=> hrdata == {31'h0, $past(lut_active)};
    endproperty
    a_stat: assert property (p_stat)
        else $error("status bit differs from table decision");
    property p_resp;
        hresp == 1'b0 && hreadyout == 1'b1;
    endproperty
    a_resp: assert property (p_resp)
        else $error("bus answer not ready or not okay");
endmodule // fluh_top_monitor
`default_nettype wire

/* tb/fluh_fan_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Fan on the pulled-up open-drain line
// ----
module fluh_fan_model
(
    input wire logic hclk,
    input wire logic pwm_o,
    input wire logic pwm_oe,
    input wire logic clr,
    output logic line,
    output int unsigned high_cnt
);
    assign line = pwm_oe ? pwm_o : 1'b1;
    always @(posedge hclk)
    begin
        if (clr)
            high_cnt <= 0;
        else
            high_cnt <= high_cnt + line;
    end
endmodule // fluh_fan_model
`default_nettype wire

/* tb/fluh_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fluh_defines.vh"
// ----
// Testbench
// ----
module fluh_top_tb;
    localparam int SDIV = 4;
    localparam logic [31:0] A_CTL = `FLUH_IDX_CTRL * 4;
    localparam logic [31:0] A_OFF = `FLUH_IDX_OFFSET * 4;
    localparam logic [31:0] A_HYS = `FLUH_IDX_HYST * 4;
    localparam logic [31:0] A_E1T = `FLUH_IDX_E1TEMP * 4;
    localparam logic [31:0] A_E1D = `FLUH_IDX_E1DUTY * 4;
    localparam logic [31:0] A_STA = `FLUH_IDX_STATUS * 4;
    localparam logic [31:0] A_PWM = `FLUH_IDX_PWMVAL * 4;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clr;
    logic lut_active, pwm_o, pwm_oe, line, on;
    logic [1:0] htrans;
    logic [2:0] hsize, m;
    logic [4:0] hy;
    logic [5:0] of;
    logic [7:0] pwm_value, et, ed;
    logic [10:0] remote_temp, r;
    logic [31:0] haddr, hwdata, hrdata, rd, lim;
    int unsigned high_cnt, per, dv;
    int n_errors = 0;
    int n_tests = 0;
    assign hready = hreadyout;
    fluh_top #(.SLOW_DIV(15'(SDIV))) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .remote_temp(remote_temp),
        .lut_active(lut_active), .pwm_value(pwm_value),
        .pwm_o(pwm_o), .pwm_oe(pwm_oe));
    fluh_fan_model fan (.hclk(hclk), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
        .clr(clr), .line(line), .high_cnt(high_cnt));
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("wrong value %s: expected %h, seen %h", what, e, g);
            n_errors++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Whole-word single transfer; read data lands in rd
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(logic [31:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(logic [31:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    function automatic logic [7:0] duty(logic [7:0] e, logic [2:0] md);
        return (md[1] && md[2]) ? e : {2'b00, e[5:0]};
    endfunction
    function automatic logic next_on(logic s, logic [10:0] t,
        logic [7:0] e, logic [5:0] o, logic [4:0] h, logic hr);
        int rg, lm, th;
        rg = hr ? t[10:2] : {t[10:3], 1'b0};
        lm = {e[6:0], e[7] & hr} + 2 * o;
        th = (lm > 2 * h) ? lm - 2 * h : 0;
        return (rg > lm) ? 1'b1 : ((rg <= th) ? 1'b0 : s);
    endfunction
    initial
    begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        $display("watchdog expired");
        report_and_stop;
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b000;
        hwdata = 32'h0;
        remote_temp = 11'h000;
        clr = 1'b0;
        rd = $urandom(32'h49cf4fe1);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rc(A_HYS, `FLUH_RST_HYST);
        rc(A_E1T, `FLUH_RST_E1TEMP);
        rc(A_E1D, `FLUH_RST_E1DUTY);
        rc(A_OFF, `FLUH_RST_OFFSET);
        rc(32'h100, 32'h0);
        rc(A_HYS + 1, 32'h0);
        wr(A_E1T, 32'h12);
        rc(A_E1T, `FLUH_RST_E1TEMP);
        wr(A_CTL, 32'h20);
        wr(A_HYS, 32'hff);
        rc(A_HYS, 32'h1f);
        wr(A_OFF, 32'hff);
        rc(A_OFF, 32'h3f);
        $display("test registers done");
        for (int i = 0; i < 8; i++)
        begin
            m = i[2:0];
            wr(A_CTL, {27'h1, 2'b00, m});
            wr(A_E1T, 32'hff);
            wr(A_E1D, 32'hff);
            rc(A_E1T, m[0] ? 32'hff : 32'h7f);
            rc(A_E1D, {24'h0, duty(8'hff, m)});
        end
        $display("test modes done");
        for (int i = 0; i < 40; i++)
        begin
            m = 3'($urandom);
            et = 8'($urandom);
            ed = 8'($urandom);
            of = 6'($urandom);
            hy = 5'($urandom);
            remote_temp <= 11'h000;
            wr(A_CTL, {27'h1, 2'b00, m});
            wr(A_E1T, {24'h0, et});
            wr(A_E1D, {24'h0, ed});
            wr(A_OFF, {26'h0, of});
            wr(A_HYS, {27'h0, hy});
            on = 1'b0;
            lim = {et[6:0], et[7] & m[0]} + 2 * of;
            r = 11'(lim * 4 + $urandom_range(0, 16));
            repeat (2)
            begin
                remote_temp <= r;
                repeat (3) @(posedge hclk);
                on = next_on(on, r, et, of, hy, m[0]);
                chk("active", on, lut_active);
                chk("duty", on ? duty(ed, m) : 0, pwm_value);
                r = r - 11'($urandom_range(0, 300));
            end
        end
        $display("test decisions done");
        remote_temp <= 11'h7ff;
        for (int k = 0; k < 3; k++)
        begin
            m = (k == 0) ? 3'b000 : ((k == 1) ? 3'b110 : 3'b100);
            ed = (k == 0) ? 8'h10 : ((k == 1) ? 8'hc0 : 8'hc5);
            wr(A_CTL, {27'h1, 2'b00, m});
            wr(A_E1D, {24'h0, ed});
            dv = m[2] ? 6 : SDIV;
            per = dv * ((m[1] && m[2]) ? 256 : 64);
            repeat (2 * per) @(posedge hclk);
            chk("duty", duty(ed, m), pwm_value);
            rc(A_PWM, {24'h0, duty(ed, m)});
            rc(A_STA, 32'h1);
            clr <= 1'b1;
            @(posedge hclk);
            clr <= 1'b0;
            repeat (per) @(posedge hclk);
            #1;
            chk("fan high", dv * duty(ed, m), high_cnt);
        end
        $display("test fan done");
        report_and_stop;
    end
endmodule // fluh_top_tb
bind fluh_top fluh_top_monitor #(.SLOW_DIV(SLOW_DIV)) mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .remote_temp(remote_temp), .lut_active(lut_active),
    .pwm_value(pwm_value), .pwm_o(pwm_o), .pwm_oe(pwm_oe));
`default_nettype wire
